// >>> rtl/apm_pkg.sv
// Package of the activity power manager: timing constants, states, carriers.
// Assumes a single 50 MHz system clock shared with the core and activity sources.
package apm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W         = 6;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = 6'h00;

    // ------------------------------------------------------------------
    // Sizes and indices
    // ------------------------------------------------------------------
    localparam int CNT_W    = 16;
    localparam int N_TIMERS = 5;
    localparam int TMR_DOZE = 0;
    localparam int TMR_STBY = 1;
    localparam int TMR_PROCESSOR_HALT_REQUEST_OUT = 2;
    localparam int TMR_HK   = 3;
    localparam int TMR_PER  = 4;
    localparam int N_PLANES = 4;
    localparam int N_STATES = 4;
    localparam int DUTY_W   = 4;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 4'h0;
    localparam logic [DUTY_W-1:0] DUTY_ONE  = 4'h1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PM_ON      = 2'b00,
        PM_DOZE    = 2'b01,
        PM_STANDBY = 2'b10,
        PM_SUSPEND = 2'b11
    } apm_state_e;

    typedef enum logic [1:0]
    {
        HALT_RUN     = 2'b00,
        HALT_DRAIN   = 2'b01,
        HALT_STOPPED = 2'b10,
        HALT_RESUME  = 2'b11
    } apm_halt_e;

    typedef struct packed
    {
        logic wake;
        logic per_idle;
        logic processor_halt_request_out_exp;
        logic stby_exp;
        logic doze_exp;
    } apm_smi_s;

    localparam apm_smi_s SMI_NONE = 5'h00;

    typedef struct packed
    {
        logic [N_TIMERS-1:0][CNT_W-1:0]  limit;
        apm_smi_s                        smi_en;
        logic [N_STATES-1:0][DUTY_W-1:0] duty;
        apm_state_e [N_PLANES-1:0]       plane_state;
    } apm_cfg_s;

    typedef logic [CNT_W-1:0] apm_cnt_t;

endpackage

// >>> rtl/apm_timer.sv
// One inactivity timer counting prescaled ticks up to a programmed limit.
// Assumes restart and tick come from logic on clk_sys.
`timescale 1ns/10ps
module apm_timer
    import apm_pkg::*;
(
    // Clock and reset
    input  wire logic     clk_sys,
    input  wire logic     sys_rst,
    input  wire logic     clk_en,
    // Control
    input  wire logic     tick,
    input  wire logic     enable,
    input  wire logic     restart,
    input  wire apm_cnt_t limit,
    // Status
    output logic          expired,
    output apm_cnt_t      count
);

    apm_cnt_t cnt_reg;
    apm_cnt_t cnt_next;
    logic     exp_reg;
    logic     exp_next;

    // Holds at the limit so one inactive interval gives one expiry
    always_comb
    begin
        cnt_next = cnt_reg;
        exp_next = 1'b0;
        if (restart || !enable || limit == CNT_ZERO)
        begin
            cnt_next = CNT_ZERO;
        end
        else if (tick && cnt_reg != limit)
        begin
            cnt_next = cnt_reg + CNT_ONE;
            exp_next = (cnt_next == limit);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            cnt_reg <= CNT_ZERO;
            exp_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_reg <= cnt_next;
            exp_reg <= exp_next;
        end
    end

    assign expired = exp_reg;
    assign count   = cnt_reg;

endmodule

// >>> rtl/apm_power_management_unit.sv
// Power management unit: activity timers, SMI causes, halt sequencing, planes.
// Assumes activity, command and core status inputs are synchronous to clk_sys.
//
// Behaviour
// [RULE_01] Doze, standby and suspend inactivity timers
// [RULE_02] Timer expiry can raise an SMI
// [RULE_03] Activity while powered down raises SMI
// [RULE_04] Three power-down states: doze, standby, suspend
// [RULE_05] House-keeping timer absorbs bursts without waking
// [RULE_06] Peripheral timer flags peripheral inactivity
// [RULE_07] Halt request throttles in every state
// [RULE_08] Independent power plane disable outputs
// [RULE_09] Halt only after core drains work
// [RULE_10] Clocks stopped, state held while suspended
// [RULE_11] Resume exactly where execution stopped
// [RULE_12] Activity restarts the matching timer
// [RULE_13] Software steps states down, restores on wake
`timescale 1ns/10ps
module apm_power_management_unit
    import apm_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    // Activity sources
    input  wire logic                  sys_act,
    input  wire logic                  hk_act,
    input  wire logic                  per_act,
    // Management software
    input  wire apm_cfg_s              cfg,
    input  wire apm_state_e            state_req,
    input  wire logic                  state_req_vld,
    input  wire apm_smi_s              smi_clr,
    // Core handshake
    input  wire logic                  core_quiesced,
    // Outputs
    output logic                       smi_out,
    output apm_smi_s                   smi_cause,
    output apm_state_e                 pm_state,
    output logic                       processor_halt_request_out,
    output logic                       clk_stop_out,
    output logic [N_PLANES-1:0]        plane_off,
    output logic                       per_idle,
    output logic                       hk_busy
);

    // ------------------------------------------------------------------
    // Prescaler and timers
    // ------------------------------------------------------------------
    logic [PRE_W-1:0]    pre_reg;
    logic [PRE_W-1:0]    pre_next;
    logic                tick;
    logic [N_TIMERS-1:0] t_en;
    logic [N_TIMERS-1:0] t_restart;
    logic [N_TIMERS-1:0] t_exp;
    apm_cnt_t            t_cnt [N_TIMERS];
    logic                hk_busy_reg;
    logic                hk_busy_next;

    always_comb
    begin
        tick     = (pre_reg == PRE_LAST);
        pre_next = tick ? PRE_ZERO : pre_reg + 6'h01;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            pre_reg <= PRE_ZERO;
        else if (clk_en)
            pre_reg <= pre_next;
    end

    always_comb
    begin
        t_en                 = {N_TIMERS{1'b1}};
        t_restart            = {N_TIMERS{sys_act}};  // [RULE_12]
        t_en[TMR_HK]         = hk_busy_reg;
        t_restart[TMR_HK]    = hk_act;               // [RULE_12]
        t_restart[TMR_PER]   = per_act;              // [RULE_12]
    end

    // Graded doze, standby and suspend timers plus house-keeping and peripheral
    genvar gi;
    generate
        for (gi = 0; gi < N_TIMERS; gi++)
        begin : g_tmr
            apm_timer u_tmr                          // [RULE_01]
            (
                .clk_sys (clk_sys),
                .sys_rst (sys_rst),
                .clk_en  (clk_en),
                .tick    (tick),
                .enable  (t_en[gi]),
                .restart (t_restart[gi]),
                .limit   (cfg.limit[gi]),
                .expired (t_exp[gi]),
                .count   (t_cnt[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Power state, house-keeping and peripheral flags
    // ------------------------------------------------------------------
    apm_state_e pm_state_reg;
    apm_state_e pm_state_next;
    logic       per_idle_reg;
    logic       per_idle_next;
    logic       low_power;

    always_comb
    begin
        low_power     = (pm_state_reg == PM_DOZE) || (pm_state_reg == PM_STANDBY);
        pm_state_next = state_req_vld ? state_req : pm_state_reg;  // [RULE_04]
        hk_busy_next  = hk_busy_reg;
        if (pm_state_reg == PM_ON || sys_act)
            hk_busy_next = 1'b0;
        else if (low_power && hk_act)
            hk_busy_next = 1'b1;                     // [RULE_05]
        else if (t_exp[TMR_HK])
            hk_busy_next = 1'b0;
        per_idle_next = per_idle_reg;
        if (t_exp[TMR_PER])
            per_idle_next = 1'b1;                    // [RULE_06]
        else if (per_act)
            per_idle_next = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            pm_state_reg <= PM_ON;
            hk_busy_reg  <= 1'b0;
            per_idle_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            pm_state_reg <= pm_state_next;
            hk_busy_reg  <= hk_busy_next;
            per_idle_reg <= per_idle_next;
        end
    end

    // ------------------------------------------------------------------
    // SMI causes
    // ------------------------------------------------------------------
    apm_smi_s smi_reg;
    apm_smi_s smi_next;
    apm_smi_s smi_set;
    logic     smi_out_reg;
    logic     smi_out_next;

    // Set beats clear so an event landing on the clear is kept
    always_comb
    begin
        smi_set          = SMI_NONE;
        smi_set.doze_exp = t_exp[TMR_DOZE] && pm_state_reg == PM_ON;     // [RULE_02]
        smi_set.stby_exp = t_exp[TMR_STBY] && pm_state_reg < PM_STANDBY; // [RULE_02]
        smi_set.processor_halt_request_out_exp = t_exp[TMR_PROCESSOR_HALT_REQUEST_OUT] && pm_state_reg < PM_SUSPEND; // [RULE_02]
        smi_set.per_idle = t_exp[TMR_PER];
        smi_set.wake     = sys_act && pm_state_reg != PM_ON;             // [RULE_03]
        smi_next         = (smi_reg & ~smi_clr) | (smi_set & cfg.smi_en);
        smi_out_next     = |smi_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            smi_reg     <= SMI_NONE;
            smi_out_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            smi_reg     <= smi_next;
            smi_out_reg <= smi_out_next;
        end
    end

    // ------------------------------------------------------------------
    // Halt sequencing and throttle
    // ------------------------------------------------------------------
    apm_halt_e           halt_reg;
    apm_halt_e           halt_next;
    logic                resume_pend_reg;
    logic                resume_pend_next;
    logic [DUTY_W-1:0]   phase_reg;
    logic [DUTY_W-1:0]   phase_next;
    logic                halt_out_reg;
    logic                halt_out_next;
    logic                stop_reg;
    logic                stop_next;
    logic [N_PLANES-1:0] plane_reg;
    logic [N_PLANES-1:0] plane_next;
    logic                throttle;

    always_comb
    begin
        halt_next        = halt_reg;
        resume_pend_next = resume_pend_reg;
        if (pm_state_reg != PM_SUSPEND)
            resume_pend_next = 1'b0;
        unique case (halt_reg)
            HALT_RUN:
                if (pm_state_reg == PM_SUSPEND && !resume_pend_reg)
                    halt_next = HALT_DRAIN;
            HALT_DRAIN:
                if (sys_act)
                    halt_next = HALT_RESUME;
                else if (core_quiesced)
                    halt_next = HALT_STOPPED;        // [RULE_09]
            HALT_STOPPED:
                if (sys_act)
                    halt_next = HALT_RESUME;         // [RULE_11]
            HALT_RESUME:
                if (!core_quiesced)
                    halt_next = HALT_RUN;
        endcase
        if (sys_act && (halt_reg == HALT_DRAIN || halt_reg == HALT_STOPPED))
            resume_pend_next = 1'b1;
        // Throttle pauses while house-keeping bursts are served
        phase_next    = phase_reg + DUTY_ONE;
        throttle      = (halt_next == HALT_RUN) && !hk_busy_reg && (phase_reg < cfg.duty[pm_state_reg]); // [RULE_07]
        halt_out_next = throttle || halt_next == HALT_DRAIN || halt_next == HALT_STOPPED;
        stop_next     = (halt_next == HALT_STOPPED);  // [RULE_10]
        for (int i = 0; i < N_PLANES; i++)
            plane_next[i] = (cfg.plane_state[i] != PM_ON) && (pm_state_reg >= cfg.plane_state[i]); // [RULE_08]
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            halt_reg        <= HALT_RUN;
            resume_pend_reg <= 1'b0;
            phase_reg       <= DUTY_ZERO;
            halt_out_reg    <= 1'b0;
            stop_reg        <= 1'b0;
            plane_reg       <= '0;
        end
        else if (clk_en)
        begin
            halt_reg        <= halt_next;
            resume_pend_reg <= resume_pend_next;
            phase_reg       <= phase_next;
            halt_out_reg    <= halt_out_next;
            stop_reg        <= stop_next;
            plane_reg       <= plane_next;
        end
    end

    assign smi_out                    = smi_out_reg;
    assign smi_cause                  = smi_reg;
    assign pm_state                   = pm_state_reg;
    assign processor_halt_request_out = halt_out_reg;
    assign clk_stop_out               = stop_reg;
    assign plane_off                  = plane_reg;
    assign per_idle                   = per_idle_reg;
    assign hk_busy                    = hk_busy_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    doze_smi_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_02]
        clk_en && t_exp[TMR_DOZE] && pm_state_reg == PM_ON && cfg.smi_en.doze_exp |=> smi_cause.doze_exp && smi_out)
        else $error("doze expiry did not raise SMI");

    wake_smi_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_03]
        clk_en && sys_act && pm_state_reg != PM_ON && cfg.smi_en.wake |=> smi_cause.wake && smi_out)
        else $error("activity in power down did not raise SMI");

    hk_absorb_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_05]
        clk_en && hk_act && !sys_act && low_power && !state_req_vld |=> hk_busy && pm_state == $past(pm_state_reg))
        else $error("house-keeping burst not absorbed");

    per_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_06]
        clk_en && t_exp[TMR_PER] |=> per_idle)
        else $error("peripheral idle flag missing");

    throttle_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_07]
        clk_en && halt_reg == HALT_RUN && pm_state_reg == PM_ON && phase_reg < cfg.duty[PM_ON] && !hk_busy_reg
        |=> processor_halt_request_out)
        else $error("throttle did not assert halt request");

    plane_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_08]
        clk_en && pm_state_reg == PM_SUSPEND && cfg.plane_state[0] != PM_ON |=> plane_off[0])
        else $error("power plane not removed");

    drain_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_09]
        clk_en && halt_reg == HALT_DRAIN && !core_quiesced && !sys_act
        |=> !clk_stop_out && processor_halt_request_out)
        else $error("clocks stopped before core drained");

    stop_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_10]
        clk_stop_out && !sys_act && !state_req_vld |=> $stable(pm_state) && clk_stop_out)
        else $error("state changed while clocks stopped");

    resume_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_11]
        clk_en && halt_reg == HALT_STOPPED && sys_act |=> !processor_halt_request_out && !clk_stop_out)
        else $error("halt not released on wake");

    restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_12]
        clk_en && sys_act |=> t_cnt[TMR_DOZE] == CNT_ZERO && t_cnt[TMR_PROCESSOR_HALT_REQUEST_OUT] == CNT_ZERO)
        else $error("activity did not restart timers");

endmodule

// >>> tb/apm_core_model.sv
// Behavioural processor core answering the halt request of the power manager.
// Assumes halt request from the unit under test and a drain latency from the bench.
`timescale 1ns/10ps
module apm_core_model
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Halt handshake
    input  wire logic       halt_req,
    input  wire logic [3:0] lat,
    output logic            core_quiesced
);
    // ------------------------------------------------------------------
    // Drain and restart
    // ------------------------------------------------------------------
    logic [3:0] wait_reg;

    // Slow answers mimic a core still finishing bus cycles
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            core_quiesced <= 1'b0;
            wait_reg      <= 4'h0;
        end
        else if (halt_req == core_quiesced)
            wait_reg <= 4'h0;
        else if (wait_reg >= lat)
        begin
            core_quiesced <= halt_req;
            wait_reg      <= 4'h0;
        end
        else
            wait_reg <= wait_reg + 4'h1;
    end
endmodule

// >>> tb/tb.sv
// Self-checking bench of the power management unit with a core model.
// Assumes the core model is compiled first; one 50 MHz clock.
`timescale 1ns/10ps
module tb
    import apm_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        sys_act = 1'b0;
    logic        hk_act = 1'b0;
    logic        per_act = 1'b0;
    apm_cfg_s    cfg = '0;
    apm_state_e  state_req = PM_ON;
    logic        state_req_vld = 1'b0;
    apm_smi_s    smi_clr = SMI_NONE;
    logic [3:0]  lat = 4'h0;
    logic        core_quiesced;
    logic        smi_out;
    apm_smi_s    smi_cause;
    apm_state_e  pm_state;
    logic        halt;
    logic        clk_stop_out;
    logic [3:0]  plane_off;
    logic        per_idle;
    logic        hk_busy;
    int          err_count = 0;
    int          checked = 0;
    logic [31:0] lfsr = 32'h139A083B;
    apm_state_e  pm_q[$];
    apm_smi_s    smi_q[$];
    apm_state_e  pm_last = PM_ON;
    apm_smi_s    smi_last = SMI_NONE;

    always #10 clk_sys = ~clk_sys;

    apm_power_management_unit dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .sys_act(sys_act),
        .hk_act(hk_act), .per_act(per_act), .cfg(cfg), .state_req(state_req), .state_req_vld(state_req_vld),
        .smi_clr(smi_clr), .core_quiesced(core_quiesced), .smi_out(smi_out), .smi_cause(smi_cause),
        .pm_state(pm_state), .processor_halt_request_out(halt), .clk_stop_out(clk_stop_out),
        .plane_off(plane_off), .per_idle(per_idle), .hk_busy(hk_busy));

    apm_core_model u_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .halt_req(halt), .lat(lat),
        .core_quiesced(core_quiesced));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [3:0] plane_exp(input int s);
        plane_exp = 4'h0;
        for (int i = 0; i < N_PLANES; i++)
            plane_exp[i] = (cfg.plane_state[i] != PM_ON) && (s >= int'(cfg.plane_state[i]));
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
    endtask

    task automatic wait_for(ref logic sig, input logic lvl, output int n);
        n = 0;
        while (sig !== lvl && n < 300)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 300)
        begin
            err_count++;
            $display("ERROR at %0t: wait limit, got %0h expected %0h", $time, sig, lvl);
        end
    endtask

    task automatic set_state(input apm_state_e s);
        pm_q.push_back(s);
        state_req = s;
        state_req_vld = 1'b1;
        @(negedge clk_sys);
        state_req_vld = 1'b0;
    endtask

    task automatic clear_smi(input apm_smi_s m);
        smi_q.push_back(SMI_NONE);
        smi_clr = m;
        @(negedge clk_sys);
        smi_clr = SMI_NONE;
    endtask

    // ------------------------------------------------------------------
    // Output watcher: every pm_state or smi_cause change must match the oldest note
    // ------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        #1;
        if (!sys_rst && pm_state !== pm_last)
        begin
            check(pm_state, (pm_q.size() > 0) ? pm_q.pop_front() : pm_last);
            pm_last = pm_state;
        end
        if (!sys_rst && smi_cause !== smi_last)
        begin
            check(smi_cause, (smi_q.size() > 0) ? smi_q.pop_front() : smi_last);
            smi_last = smi_cause;
        end
    end

    // Cut a hang short; a full run needs well under 10k cycles
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        err_count++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int       n;
        int       d;
        apm_smi_s e;
        cfg.smi_en = 5'h1F;
        cyc(3);
        sys_rst = 1'b0;
        cyc(1);
        check(pm_state, PM_ON);
        check({smi_out, smi_cause, halt, clk_stop_out, plane_off, per_idle, hk_busy}, 32'h0);
        // Inactivity timers: restarts hold off expiry, then expiry raises its cause
        for (int t = 0; t < 3; t++)
        begin
            cfg.limit[t] = 16'h0003;
            for (int k = 0; k < 6; k++)
            begin
                pulse(sys_act);
                lfsr = lfsr_next(lfsr);
                if (k < 5)
                    cyc(20 + int'(lfsr % 60));
            end
            e = SMI_NONE;
            e[t] = 1'b1;
            smi_q.push_back(e);
            wait_for(smi_out, 1'b1, n);
            check(n >= 95 && n <= 160, 1);
            cfg.limit[t] = CNT_ZERO;
            clear_smi(e);
            check(smi_out, 0);
        end
        // Peripheral idle flag and cause
        cfg.limit[TMR_PER] = 16'h0002;
        pulse(per_act);
        smi_q.push_back(5'h08);
        wait_for(per_idle, 1'b1, n);
        cfg.limit[TMR_PER] = CNT_ZERO;
        pulse(per_act);
        cyc(2);
        check(per_idle, 0);
        clear_smi(5'h08);
        // Doze and standby: house-keeping absorbed, system activity wakes
        cfg.limit[TMR_HK] = 16'h0002;
        for (int s = 1; s < 3; s++)
        begin
            set_state(apm_state_e'(s));
            cyc(2);
            pulse(hk_act);
            check(hk_busy, 1);
            wait_for(hk_busy, 1'b0, n);
            pulse(hk_act);
            smi_q.push_back(5'h10);
            pulse(sys_act);
            cyc(1);
            check({smi_out, hk_busy}, 2'b10);
            clear_smi(5'h10);
            set_state(PM_ON);
        end
        // Throttle duty and plane removal in on, doze and standby
        cfg.plane_state[0] = PM_DOZE;
        cfg.plane_state[1] = PM_STANDBY;
        cfg.plane_state[2] = PM_SUSPEND;
        cfg.plane_state[3] = PM_ON;
        for (int s = 0; s < 3; s++)
        begin
            lfsr = lfsr_next(lfsr);
            d = 1 + int'(lfsr % 15);
            cfg.duty[s] = DUTY_W'(d);
            if (s != 0)
                set_state(apm_state_e'(s));
            cyc(3);
            n = 0;
            repeat (32)
            begin
                @(negedge clk_sys);
                n += int'(halt);
            end
            check(n, 2 * d);
            check(plane_off, plane_exp(s));
            cfg.duty[s] = DUTY_ZERO;
            cyc(20);
        end
        // Suspend entry, frozen hold, wake; prompt then slow core
        for (int k = 0; k < 2; k++)
        begin
            lat = (k == 0) ? 4'h0 : 4'h6;
            set_state(PM_SUSPEND);
            wait_for(halt, 1'b1, n);
            check({clk_stop_out, core_quiesced}, 2'b00);
            wait_for(clk_stop_out, 1'b1, n);
            check(core_quiesced, 1);
            check(n >= int'(lat), 1);
            check(plane_off, plane_exp(3));
            clk_en = 1'b0;
            cyc(10);
            check({pm_state, halt, clk_stop_out, smi_cause}, {PM_SUSPEND, 2'b11, SMI_NONE});
            clk_en = 1'b1;
            smi_q.push_back(5'h10);
            pulse(sys_act);
            cyc(1);
            check({halt, clk_stop_out}, 2'b00);
            wait_for(core_quiesced, 1'b0, n);
            cyc(20);
            check(halt, 0);
            clear_smi(5'h10);
            set_state(PM_ON);
            cyc(5);
        end
        close_out();
    end
endmodule
